/* dv/spc_chk.sv */
// Purpose: port checker for the socket control bank
// Assumes: one clock domain, reset low
// Notes: socket A checked in depth, socket B through writes
`timescale 1ns/1ps
`default_nettype none
module spc_chk
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register port
   input wire logic reg_wr,
   input wire logic mem_space,
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   // Power switch side
   input wire logic [1:0] switch_ack,
   input wire logic [1:0] switch_req_q,
   input wire logic [3:0] core_supply_request_q,
   input wire logic [3:0] program_supply_request_q,
   input wire logic [1:0] socket_power_on_flag_q,
   // Card side
   input wire logic [1:0] card_output_enable_q,
   input wire logic [1:0] card_reset_q,
   input wire logic [1:0] modem_wake_enable_q,
   input wire logic [1:0] socket_kind_flag_q,
   input wire logic [1:0] change_irq_to_host_bus_q,
   input wire logic [7:0] function_irq_route_q,
   input wire logic [1:0] socket_change_event_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // Write decodes; a later write to the same place must wait 3 cycles
   wire logic pw_a = reg_wr && !mem_space && reg_addr == 12'h002;
   wire logic gw_b = reg_wr && !mem_space && reg_addr == 12'h043;
   chk_vcc_code: assert property (core_supply_request_q[1:0] != 2'b01)
      else $error("vcc code");
   chk_vpp_code: assert property (program_supply_request_q[1:0] != 2'b11)
      else $error("vpp code");
   chk_vpp_gated: assert property (core_supply_request_q[1:0] == 2'b00 |->
      program_supply_request_q[1:0] == 2'b00) else $error("vpp without vcc");
   chk_flag_on: assert property ($rose(socket_power_on_flag_q[0]) |->
      core_supply_request_q[1:0] != 2'b00) else $error("flag with vcc off");
   chk_req_held: assert property (switch_req_q[0] && !switch_ack[0] |=>
      switch_req_q[0]) else $error("request dropped");
   chk_oe_write: assert property (pw_a |-> ##4
      card_output_enable_q[0] == $past(reg_wdata[7], 4)) else $error("oe");
   chk_genctl_b: assert property (gw_b |-> ##4 {modem_wake_enable_q[1],
      ~card_reset_q[1], socket_kind_flag_q[1], change_irq_to_host_bus_q[1],
      function_irq_route_q[7:4]} == $past(reg_wdata, 4)) else $error("genctl B");
   chk_wake_off: assert property (!modem_wake_enable_q[0] [*3] |->
      !socket_change_event_q[0]) else $error("event without wake");
   // Main scenarios
   cv_power: cover property ($rose(socket_power_on_flag_q[0]));
   cv_wake: cover property (socket_change_event_q[0]);
   cv_slow: cover property (switch_req_q[1] [*2]);
endmodule : spc_chk
bind spc_top spc_chk chk_u
(
   .clk(clk),
   .nrst(nrst),
   .reg_wr(reg_wr),
   .mem_space(mem_space),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .switch_ack(switch_ack),
   .switch_req_q(switch_req_q),
   .core_supply_request_q(core_supply_request_q),
   .program_supply_request_q(program_supply_request_q),
   .socket_power_on_flag_q(socket_power_on_flag_q),
   .card_output_enable_q(card_output_enable_q),
   .card_reset_q(card_reset_q),
   .modem_wake_enable_q(modem_wake_enable_q),
   .socket_kind_flag_q(socket_kind_flag_q),
   .change_irq_to_host_bus_q(change_irq_to_host_bus_q),
   .function_irq_route_q(function_irq_route_q),
   .socket_change_event_q(socket_change_event_q)
);
`default_nettype wire

/* dv/spc_sw_model.sv */
// Purpose: power switch stand-in for both sockets
// Assumes: request level held until acknowledged
// Notes: socket B answers a cycle later than socket A
`timescale 1ns/1ps
`default_nettype none
module spc_sw_model (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Handshake
   input wire logic [1:0] req,
   output logic [1:0] ack
);
   logic slow_q;
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
      begin
         slow_q <= 1'b0;
         ack <= 2'b00;
      end
      else
      begin
         slow_q <= req[1];
         ack <= {req[1] & slow_q, req[0]};
      end
endmodule : spc_sw_model
`default_nettype wire

/* dv/tb_top.sv */
// Purpose: self-checking bench for the socket control bank
// Assumes: switch model acks every supply request
// Notes: data from a fixed-seed shift register
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic ms_r = 1'b0, sb_r = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00, rdata, d, route;
   logic [1:0] ack, req, pin = 2'b00, oe, rst, wake, kind, hb, ev, flag;
   logic [3:0] vcc, vpp;
   logic [31:0] seed = 32'hd04d_510d;
   int n_errors = 0, tests_run = 0, s;
   always #5 clk = ~clk;
   spc_top dut_u (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .mem_space(ms_r), .mem_socket_b(sb_r), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata_q(rdata), .switch_ack(ack), .switch_req_q(req),
      .core_supply_request_q(vcc), .program_supply_request_q(vpp),
      .battery_or_wake_pin(pin), .card_output_enable_q(oe), .card_reset_q(rst),
      .modem_wake_enable_q(wake), .socket_kind_flag_q(kind), .change_irq_to_host_bus_q(hb),
      .function_irq_route_q(route), .socket_change_event_q(ev), .socket_power_on_flag_q(flag));
   spc_sw_model sw_u (.clk(clk), .nrst(nrst), .req(req), .ack(ack));
   ////////////////////////////////////////////////////////////////////
   function automatic logic [1:0] vcc_of(input logic [1:0] v);
      return (v == 2'b01) ? 2'b00 : v;
   endfunction : vcc_of
   // Fixed-seed shift register step for repeatable random data
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr
   task automatic check(input logic [7:0] got, exp);
      tests_run++;
      if (got !== exp)
      begin
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
         n_errors++;
      end
   endtask : check
   // One access, then a gap so outputs settle before the next
   task automatic acc(input logic wr, ms, sb, input logic [11:0] a, input logic [7:0] dt);
      @(posedge clk);
      {ms_r, sb_r, reg_addr, reg_wdata} <= {ms, sb, a, dt};
      reg_wr <= wr;
      reg_rd <= !wr;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (5) @(posedge clk);
      for (int i = 0; i < 30 && req !== 2'b00; i++)
         @(posedge clk);
      repeat (4) @(posedge clk);
   endtask : acc
   task automatic stop_test();
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////////////
   // Run is several hundred cycles; a hang is cut well past that
   initial
   begin
      #300_000;
      n_errors++;
      stop_test();
   end
   initial
   begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      acc(0, 0, 0, 12'h043, 8'h00);
      check(rdata, 8'h00);
      check({oe, rst}, 8'h03);
      acc(1, 0, 0, 12'h002, 8'hFF);
      acc(0, 0, 0, 12'h002, 8'h00);
      check(rdata, 8'h9B);
      acc(0, 0, 0, 12'h010, 8'h00);
      check(rdata, 8'h00);
      d = seed[7:0];
      acc(1, 1, 1, 12'h802, d);
      acc(0, 0, 0, 12'h042, 8'h00);
      check(rdata, d & 8'h9B);
      // Every supply code pair, output enable kept on
      for (int i = 0; i < 16; i++)
      begin
         acc(1, 0, 0, 12'h002, {3'b100, i[3:2], 1'b0, i[1:0]});
         d = (vcc_of(i[3:2]) == 2'b00 || i[1:0] == 2'b11) ? 8'h00 : {6'h0, i[1:0]};
         check({vcc[1:0], vpp[1:0]}, {vcc_of(i[3:2]), d[1:0]});
         check({oe[0], flag[0]}, {1'b1, vcc_of(i[3:2]) != 2'b00});
      end
      // Socket B through the slower switch path: 5 V core, 12 V program
      acc(1, 0, 0, 12'h042, 8'h92);
      check({vcc[3:2], vpp[3:2], oe[1], flag[1]}, 8'h2B);
      // General control: corner codes, then random socket, form and data
      for (int i = 0; i < 10; i++)
      begin
         seed = lfsr(seed);
         d = (i == 0) ? 8'h82 : (i == 1) ? 8'h7F : seed[7:0];
         s = int'(seed[8]);
         acc(1, seed[9], seed[8], seed[9] ? 12'h803 : {5'h0, seed[8], 6'h03}, d);
         acc(0, 0, 0, {5'h0, seed[8], 6'h03}, 8'h00);
         check(rdata, d);
         check({wake[s], ~rst[s], kind[s], hb[s], route[s*4 +: 4]}, d);
      end
      // Wake input follows pin only while enabled
      acc(1, 0, 0, 12'h003, 8'h80);
      pin <= 2'b01;
      repeat (5) @(posedge clk);
      check({7'h0, ev[0]}, 8'h01);
      acc(1, 0, 0, 12'h003, 8'h00);
      check({7'h0, ev[0]}, 8'h00);
      // Mid-run reset must clear registers written earlier
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      acc(0, 0, 0, 12'h002, 8'h00);
      check(rdata, 8'h00);
      check({oe, rst, flag}, 8'h0C);
      stop_test();
   end
endmodule : tb_top
`default_nettype wire

/* pkg/spc_pkg.sv */
// Purpose: constants for the socket power and interrupt control registers
// Assumes: byte-wide register port indexed as the socket register index
// Notes: two sockets, A at index base 00h, B at 40h
// Overview of operation
// RULE1: card outputs driven only when output enable set
// RULE2: power reserved bits read zero, ignore writes
// RULE3: core supply field: 10 five, 11 three, else off
// RULE4: program supply: 01 follows core, 10 twelve, else off
// RULE5: program supply ignored while core supply off
// RULE6: bit 7 turns shared pin into wake input
// RULE7: bit 6 zero holds card in reset
// RULE8: bit 5 records memory or I/O card
// RULE9: bit 4 sends change events to host bus lines
// RULE10: route field: 0 none, 1 IRQ1, 2 SMI, n IRQn
// RULE11: power register per socket at 02h, 42h, 802h
// RULE12: general control at 03h, 43h, 803h, resets zero
// RULE13: power-on flag shows core supply turned on
// RULE14: wake enabled makes change bit 0 follow pin
// RULE15: supply change sent to switch before flag updates
package spc_pkg;
   localparam logic [7:0] SPC_IDX_POWER = 8'h02;
   localparam logic [7:0] SPC_IDX_GENCTL = 8'h03;
   localparam logic [7:0] SPC_SOCKET_B_BASE = 8'h40;
   localparam logic [11:0] SPC_MEM_POWER = 12'h0802;
   localparam logic [11:0] SPC_MEM_GENCTL = 12'h0803;
   localparam logic [7:0] SPC_POWER_RESET = 8'h00;
   localparam logic [7:0] SPC_GENCTL_RESET = 8'h00;
   localparam logic [7:0] SPC_POWER_WMASK = 8'h9B;
   localparam int SPC_OE_BIT = 7;
   localparam int SPC_WAKE_BIT = 7;
   localparam int SPC_RESET_BIT = 6;
   localparam int SPC_KIND_BIT = 5;
   localparam int SPC_ROUTE_BIT = 4;
   // Supply level codes seen by the power switch
   localparam logic [1:0] SPC_VCC_5V = 2'b10;
   localparam logic [1:0] SPC_VCC_3V = 2'b11;
   localparam logic [1:0] SPC_VPP_VCC = 2'b01;
   localparam logic [1:0] SPC_VPP_12V = 2'b10;
   localparam logic [1:0] SPC_OFF = 2'b00;
   localparam logic [3:0] SPC_ROUTE_NONE = 4'h0;
   localparam logic [3:0] SPC_ROUTE_SMI = 4'h2;
endpackage : spc_pkg

/* verilog/spc_socket.sv */
// Purpose: one socket's power and general control registers
// Assumes: write strobe and data from the same clock domain
// Notes: supply request handed to the switch via req/ack handshake
`timescale 1ns/1ps
`default_nettype none
module spc_socket
   import spc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register writes
   input wire logic wr_power,
   input wire logic wr_genctl,
   input wire logic [7:0] wdata,
   // Power switch handshake
   input wire logic switch_ack,
   // State out
   output logic [7:0] power_q,
   output logic [7:0] genctl_q,
   output logic [1:0] vcc_req_q,
   output logic [1:0] vpp_req_q,
   output logic switch_req_q,
   output logic power_on_q
);
   ////////////////////////////////////////////////////////////////////////
   logic [1:0] vcc_d;
   logic [1:0] vpp_d;

   // Decode requested levels
   always_comb
   begin
      // RULE3: core supply decode
      unique case (power_q[4:3])
         SPC_VCC_5V: vcc_d = SPC_VCC_5V;
         SPC_VCC_3V: vcc_d = SPC_VCC_3V;
         default: vcc_d = SPC_OFF;
      endcase
      // RULE4: program supply decode
      unique case (power_q[1:0])
         SPC_VPP_VCC: vpp_d = SPC_VPP_VCC;
         SPC_VPP_12V: vpp_d = SPC_VPP_12V;
         default: vpp_d = SPC_OFF;
      endcase
      // RULE5: gate on core supply
      if (vcc_d == SPC_OFF)
      begin
         vpp_d = SPC_OFF;
      end
   end

   // Register writes
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         power_q <= SPC_POWER_RESET;
         genctl_q <= SPC_GENCTL_RESET;
      end
      else
      begin
         // RULE2: reserved bits masked
         if (wr_power)
            power_q <= wdata & SPC_POWER_WMASK;
         // RULE12: full byte writable
         if (wr_genctl)
            genctl_q <= wdata;
      end
   end

   // Send changed request; a change during a pending send resends after ack
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         vcc_req_q <= SPC_OFF;
         vpp_req_q <= SPC_OFF;
         switch_req_q <= 1'b0;
         power_on_q <= 1'b0;
      end
      else
      begin
         // RULE15: forward change first
         // Wait for ack low so a stale ack cannot close the next send
         if (!switch_req_q && !switch_ack && (vcc_d != vcc_req_q || vpp_d != vpp_req_q))
         begin
            vcc_req_q <= vcc_d;
            vpp_req_q <= vpp_d;
            switch_req_q <= 1'b1;
         end
         else if (switch_req_q && switch_ack)
         begin
            switch_req_q <= 1'b0;
            // RULE13: flag after switch accepted
            power_on_q <= (vcc_req_q != SPC_OFF);
         end
      end
   end
endmodule : spc_socket
`default_nettype wire

/* verilog/spc_top.sv */
// Purpose: two-socket power and interrupt control register bank
// Assumes: byte register port, reads combinational into a flop
// Notes: pins from the card are synchronised with two flops
`timescale 1ns/1ps
`default_nettype none
module spc_top
   import spc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register port: index space or socket memory window
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic mem_space,
   input wire logic mem_socket_b,
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_q,
   // Power switch handshake per socket
   input wire logic [1:0] switch_ack,
   output logic [1:0] switch_req_q,
   output logic [3:0] core_supply_request_q,
   output logic [3:0] program_supply_request_q,
   // Card side per socket
   input wire logic [1:0] battery_or_wake_pin,
   output logic [1:0] card_output_enable_q,
   output logic [1:0] card_reset_q,
   output logic [1:0] modem_wake_enable_q,
   output logic [1:0] socket_kind_flag_q,
   output logic [1:0] change_irq_to_host_bus_q,
   output logic [7:0] function_irq_route_q,
   output logic [1:0] socket_change_event_q,
   output logic [1:0] socket_power_on_flag_q
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0] power_w [2];
   logic [7:0] genctl_w [2];
   logic [1:0] vcc_w [2];
   logic [1:0] vpp_w [2];
   logic [1:0] req_w;
   logic [1:0] pon_w;
   logic [1:0] pin_s1_q;
   logic [1:0] pin_s2_q;
   logic [1:0] wr_p;
   logic [1:0] wr_g;
   logic [1:0] hit_p;
   logic [1:0] hit_g;

   // Address decode, both the index form and memory form
   function automatic logic hit(input logic [11:0] a, input logic ms, input logic msb,
                                input int s, input logic [7:0] idx, input logic [11:0] m);
      if (ms)
         return (a == m) && (msb == s[0]);
      return a == {4'h0, idx + (s[0] ? SPC_SOCKET_B_BASE : 8'h00)};
   endfunction : hit

   ////////////////////////////////////////////////////////////////////////
   // RULE11: one copy per socket
   for (genvar s = 0; s < 2; s++)
   begin : g_sock
      assign hit_p[s] = hit(reg_addr, mem_space, mem_socket_b, s, SPC_IDX_POWER, SPC_MEM_POWER);
      assign hit_g[s] = hit(reg_addr, mem_space, mem_socket_b, s, SPC_IDX_GENCTL,
                            SPC_MEM_GENCTL);
      assign wr_p[s] = reg_wr && hit_p[s];
      assign wr_g[s] = reg_wr && hit_g[s];
      spc_socket u_sock
      (
         .clk(clk),
         .nrst(nrst),
         .wr_power(wr_p[s]),
         .wr_genctl(wr_g[s]),
         .wdata(reg_wdata),
         .switch_ack(switch_ack[s]),
         .power_q(power_w[s]),
         .genctl_q(genctl_w[s]),
         .vcc_req_q(vcc_w[s]),
         .vpp_req_q(vpp_w[s]),
         .switch_req_q(req_w[s]),
         .power_on_q(pon_w[s])
      );
   end

   // Pin synchroniser, first stage read only by second
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pin_s1_q <= 2'b00;
         pin_s2_q <= 2'b00;
      end
      else
      begin
         pin_s1_q <= battery_or_wake_pin;
         pin_s2_q <= pin_s1_q;
      end
   end

   // Card-side and switch-side outputs, registered so they never glitch
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         card_output_enable_q <= 2'b00;
         card_reset_q <= 2'b11;
         modem_wake_enable_q <= 2'b00;
         socket_kind_flag_q <= 2'b00;
         change_irq_to_host_bus_q <= 2'b00;
         function_irq_route_q <= 8'h00;
         socket_change_event_q <= 2'b00;
         switch_req_q <= 2'b00;
         core_supply_request_q <= 4'h0;
         program_supply_request_q <= 4'h0;
         socket_power_on_flag_q <= 2'b00;
      end
      else
      begin
         for (int s = 0; s < 2; s++)
         begin
            // RULE1: output enable gate
            card_output_enable_q[s] <= power_w[s][SPC_OE_BIT];
            // RULE7: reset held while bit is zero
            card_reset_q[s] <= ~genctl_w[s][SPC_RESET_BIT];
            // RULE6: wake function select
            modem_wake_enable_q[s] <= genctl_w[s][SPC_WAKE_BIT];
            // RULE8: card type flag
            socket_kind_flag_q[s] <= genctl_w[s][SPC_KIND_BIT];
            // RULE9: change event routing
            change_irq_to_host_bus_q[s] <= genctl_w[s][SPC_ROUTE_BIT];
            // RULE10: functional irq code, 2 means SMI
            function_irq_route_q[s*4 +: 4] <= genctl_w[s][3:0];
            // RULE14: change bit follows wake pin
            socket_change_event_q[s] <= genctl_w[s][SPC_WAKE_BIT] & pin_s2_q[s];
            switch_req_q[s] <= req_w[s];
            core_supply_request_q[s*2 +: 2] <= vcc_w[s];
            program_supply_request_q[s*2 +: 2] <= vpp_w[s];
            socket_power_on_flag_q[s] <= pon_w[s];
         end
      end
   end

   // Read data; unmapped reads return zero
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         reg_rdata_q <= 8'h00;
      else if (reg_rd)
      begin
         reg_rdata_q <= 8'h00;
         for (int s = 0; s < 2; s++)
         begin
            if (hit_p[s])
               reg_rdata_q <= power_w[s];
            if (hit_g[s])
               reg_rdata_q <= genctl_w[s];
         end
      end
   end
endmodule : spc_top
`default_nettype wire
